/* inc/ptr_pkg.sv */
// Purpose: shared constants and types for the program memory table read
// Assumes: one core clock, synchronous active-low reset
// Notes: word address is high pointer bits above the low pointer byte
package ptr_pkg;
	localparam int PTR_ADDR_W = 12;
	localparam int PTR_DATA_W = 16;
	localparam int PTR_BYTE_W = 8;
	localparam int PTR_HIPTR_W = 4;
	localparam int PTR_DEPTH = 4096;
	localparam int PTR_DMEM_W = 9;
	localparam logic [7:0] PTR_LATCH_RST = 8'h00;
	localparam logic [7:0] PTR_LOWPTR_RST = 8'h00;
	localparam logic [3:0] PTR_HIPTR_RST = 4'h0;
	localparam logic [8:0] PTR_DADDR_RST = 9'h000;
	localparam logic [1:0] PTR_SECTOR0 = 2'h0;
	typedef enum logic [1:0] {
		PTR_IDLE = 2'b00,
		PTR_FETCH = 2'b01,
		PTR_DONE = 2'b11
	} ptr_state_t;
endpackage : ptr_pkg

/* inc/ptr_mem_if.sv */
// Purpose: read port between the sequencer and the program memory
// Assumes: synchronous read, data valid one clock after the request
// Notes: none
`timescale 1ns/10ps
interface ptr_mem_if;
	import ptr_pkg::*;
	logic rd_en;
	logic [PTR_ADDR_W-1:0] addr;
	logic [PTR_DATA_W-1:0] rdata;
	modport seq (output rd_en, output addr, input rdata);
	modport mem (input rd_en, input addr, output rdata);
endinterface : ptr_mem_if

/* hdl/ptr_rom.sv */
// Purpose: program memory array, 4K words of 16 bits
// Assumes: contents loaded by the programming path, outside this block
// Notes: write port used only by that loader
`timescale 1ns/10ps
module ptr_rom import ptr_pkg::*; #(
	parameter int DEPTH = PTR_DEPTH
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [PTR_ADDR_W-1:0] wr_addr,
	input wire logic [PTR_DATA_W-1:0] wr_data,
	ptr_mem_if.mem port
);
	logic [PTR_DATA_W-1:0] mem_q [DEPTH];
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end
	always_ff @(posedge clk) begin
		if (port.rd_en) begin
			port.rdata <= mem_q[port.addr];
		end
	end
endmodule : ptr_rom

/* hdl/ptr_table_read.sv */
// Purpose: table read path: fetch program word, split into two bytes
// Assumes: decoder pulses one start per instruction, inputs synchronous
// Notes: result appears two clocks after the start
// Notes on behaviour
// [R01] word address is high table pointer bits joined to low pointer byte
// [R02] table reads load fetched upper byte into the high-byte latch
// [R03] high-byte latch is readable and writable by software
// [R04] every table instruction completes in two instruction cycles
// [R05] software disables interrupts around main-routine table reads
// [R06] lower fetched byte is written to the operand's data register
// [R07] program memory holds 4K words of 16 bits
// [R08] plain form targets sector 0; extended form any sector
// [R09] high-byte latch holds until next table read or software write
`timescale 1ns/10ps
module ptr_table_read import ptr_pkg::*; #(
	parameter int DEPTH = PTR_DEPTH
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic TABLE_READ_START,
	input wire logic EXTENDED_TABLE_READ_INSTR,
	input wire logic [PTR_DMEM_W-1:0] DEST_ADDR,
	input wire logic [1:0] DEST_SECTOR,
	input wire logic TABLE_POINTER_LOW_WR,
	input wire logic TABLE_POINTER_HIGH_WR,
	input wire logic LATCH_WR,
	input wire logic [PTR_BYTE_W-1:0] WR_DATA,
	input wire logic PROG_WR,
	input wire logic [PTR_ADDR_W-1:0] PROG_ADDR,
	input wire logic [PTR_DATA_W-1:0] PROG_DATA,
	output logic [PTR_BYTE_W-1:0] TABLE_POINTER_LOW,
	output logic [PTR_HIPTR_W-1:0] TABLE_POINTER_HIGH,
	output logic [PTR_BYTE_W-1:0] TABLE_HIGH_BYTE_LATCH,
	output logic DMEM_WR,
	output logic [PTR_DMEM_W-1:0] DMEM_ADDR,
	output logic [1:0] DMEM_SECTOR,
	output logic [PTR_BYTE_W-1:0] DMEM_DATA,
	output logic BUSY,
	output logic SECTOR_ERR
);
	ptr_state_t state_q, state_d;
	logic [PTR_DMEM_W-1:0] daddr_q;
	logic [1:0] dsect_q;
	logic err_d;
	ptr_mem_if mem_bus ();
	logic start_seen;
	logic in_fetch;

	// plain form may only reach sector 0
	function automatic logic plain_refused(
		input logic ext,
		input logic [1:0] sect
	);
		return !ext && sect != PTR_SECTOR0;
	endfunction : plain_refused

	// upper byte of a fetched word
	function automatic logic [PTR_BYTE_W-1:0] word_high(
		input logic [PTR_DATA_W-1:0] w
	);
		return w[PTR_DATA_W-1:PTR_BYTE_W];
	endfunction : word_high

	// lower byte of a fetched word
	function automatic logic [PTR_BYTE_W-1:0] word_low(
		input logic [PTR_DATA_W-1:0] w
	);
		return w[PTR_BYTE_W-1:0];
	endfunction : word_low

	// program word address from the two pointers
	function automatic logic [PTR_ADDR_W-1:0] word_addr(
		input logic [PTR_HIPTR_W-1:0] hi,
		input logic [PTR_BYTE_W-1:0] lo
	);
		return {hi, lo};
	endfunction : word_addr

	ptr_rom #(.DEPTH(DEPTH)) u_rom (
		.clk(MCLK),
		.wr_en(PROG_WR),
		.wr_addr(PROG_ADDR),
		.wr_data(PROG_DATA),
		.port(mem_bus.mem)
	); // [R07]

	// plain form may only address sector 0
	assign err_d = plain_refused(EXTENDED_TABLE_READ_INSTR, DEST_SECTOR); // [R08]

	// a start only counts while idle; later starts are dropped
	assign start_seen = state_q == PTR_IDLE && TABLE_READ_START;
	assign in_fetch = state_q == PTR_FETCH;

	// fetch address from the two pointers
	assign mem_bus.rd_en = start_seen && !err_d;
	assign mem_bus.addr = word_addr(TABLE_POINTER_HIGH, TABLE_POINTER_LOW); // [R01]

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PTR_IDLE: begin
				if (mem_bus.rd_en) begin
					state_d = PTR_FETCH;
				end
			end
			PTR_FETCH: begin
				state_d = PTR_DONE; // [R04]
			end
			PTR_DONE: begin
				state_d = PTR_IDLE;
			end
			default: begin
				state_d = PTR_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state_q <= PTR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			daddr_q <= PTR_DADDR_RST;
		end else if (mem_bus.rd_en) begin
			daddr_q <= DEST_ADDR;
		end
	end

	// destination sector kept for the write two clocks on
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			dsect_q <= PTR_SECTOR0;
		end else if (mem_bus.rd_en) begin
			dsect_q <= DEST_SECTOR;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			TABLE_POINTER_LOW <= PTR_LOWPTR_RST;
		end else if (TABLE_POINTER_LOW_WR) begin
			TABLE_POINTER_LOW <= WR_DATA;
		end
	end

	// only the low bits of the write data reach the high pointer
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			TABLE_POINTER_HIGH <= PTR_HIPTR_RST;
		end else if (TABLE_POINTER_HIGH_WR) begin
			TABLE_POINTER_HIGH <= WR_DATA[PTR_HIPTR_W-1:0];
		end
	end

	// table load wins over a software write in the same cycle
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			TABLE_HIGH_BYTE_LATCH <= PTR_LATCH_RST;
		end else if (in_fetch) begin
			TABLE_HIGH_BYTE_LATCH <= word_high(mem_bus.rdata); // [R02]
		end else if (LATCH_WR) begin
			TABLE_HIGH_BYTE_LATCH <= WR_DATA; // [R03]
		end // [R09]
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			DMEM_WR <= 1'b0;
		end else begin
			DMEM_WR <= in_fetch; // [R06]
		end
	end

	// write address and data hold until the next table read
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			DMEM_ADDR <= PTR_DADDR_RST;
			DMEM_SECTOR <= PTR_SECTOR0;
			DMEM_DATA <= PTR_LATCH_RST;
		end else if (in_fetch) begin
			DMEM_ADDR <= daddr_q;
			DMEM_SECTOR <= dsect_q;
			DMEM_DATA <= word_low(mem_bus.rdata); // [R06]
		end
	end

	// busy from the next state so it rises with the taking edge
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= state_d != PTR_IDLE; // [R04]
		end
	end

	// one pulse per refused plain-form start
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			SECTOR_ERR <= 1'b0;
		end else begin
			SECTOR_ERR <= start_seen && err_d; // [R08]
		end
	end
endmodule : ptr_table_read

/* tb/ptr_table_read_chk.sv */
// Purpose: port checks
// Assumes: one clock
// Notes: none
`timescale 1ns/10ps
module ptr_table_read_chk import ptr_pkg::*; (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic TABLE_READ_START,
	input wire logic EXTENDED_TABLE_READ_INSTR,
	input wire logic [8:0] DEST_ADDR,
	input wire logic [1:0] DEST_SECTOR,
	input wire logic LATCH_WR,
	input wire logic [7:0] WR_DATA,
	input wire logic [7:0] TABLE_HIGH_BYTE_LATCH,
	input wire logic DMEM_WR,
	input wire logic [8:0] DMEM_ADDR,
	input wire logic BUSY,
	input wire logic SECTOR_ERR
);
	wire ok = EXTENDED_TABLE_READ_INSTR || DEST_SECTOR == 2'h0;
	wire go = TABLE_READ_START && !BUSY;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	a_answer_two: assert property (go && ok |-> ##2 DMEM_WR)
		else $error("late write");
	a_busy_walk: assert property (go && ok |=> BUSY [*2])
		else $error("busy short");
	a_plain_refused: assert property (go && !ok |=> SECTOR_ERR ##1 !DMEM_WR)
		else $error("not refused");
	a_write_cause: assert property (DMEM_WR |-> $past(TABLE_READ_START, 2))
		else $error("stray write");
	a_dest_carry: assert property (DMEM_WR |-> DMEM_ADDR == $past(DEST_ADDR, 2))
		else $error("bad address");
	a_write_pulse: assert property (DMEM_WR |=> !DMEM_WR)
		else $error("long write");
	a_latch_hold: assert property ($changed(TABLE_HIGH_BYTE_LATCH) |->
		DMEM_WR || $past(LATCH_WR)) else $error("latch moved");
	a_latch_sw: assert property (LATCH_WR && !BUSY && !TABLE_READ_START |=>
		TABLE_HIGH_BYTE_LATCH == $past(WR_DATA)) else $error("latch lost");
	cover property (DMEM_WR);
	cover property (SECTOR_ERR);
	cover property (LATCH_WR);
endmodule : ptr_table_read_chk

/* tb/ptr_dmem_model.sv */
// Purpose: data memory beside the table read
// Assumes: one-cycle write strobe
// Notes: behavioural
`timescale 1ns/10ps
module ptr_dmem_model (
	input wire logic clk,
	input wire logic wr,
	input wire logic [8:0] addr,
	input wire logic [7:0] data
);
	logic [7:0] mem_q [512];
	always_ff @(posedge clk) begin
		if (wr) mem_q[addr] <= data;
	end
endmodule : ptr_dmem_model

/* tb/ptr_table_read_tb.sv */
// Purpose: self-checking bench
// Assumes: inputs change on the falling edge
// Notes: results queued, checked on the write strobe
`timescale 1ns/10ps
module ptr_table_read_tb;
	import ptr_pkg::*;
	logic clk = 0, rst_n = 0, st = 0, ext = 0, pw = 0, plw = 0, phw = 0, lw = 0;
	logic [8:0] da = 0, oa;
	logic [1:0] ds = 0;
	logic [7:0] wd = 0, lat, dd, v;
	logic [11:0] pa = 0, adr [12];
	logic [15:0] pd = 0, mem [4096];
	logic dw, busy, serr;
	logic [7:0] tpl;
	logic [3:0] tph;
	logic [1:0] dsec;
	logic [24:0] q [$];
	int err_count = 0, compares = 0, seed = 32'h14cb;
	ptr_table_read ptr_table_read_i (.MCLK(clk), .RST_N(rst_n),
		.TABLE_READ_START(st), .EXTENDED_TABLE_READ_INSTR(ext), .DEST_ADDR(da),
		.DEST_SECTOR(ds), .TABLE_POINTER_LOW_WR(plw), .TABLE_POINTER_HIGH_WR(phw),
		.LATCH_WR(lw), .WR_DATA(wd), .PROG_WR(pw), .PROG_ADDR(pa), .PROG_DATA(pd),
		.TABLE_POINTER_LOW(tpl), .TABLE_POINTER_HIGH(tph),
		.TABLE_HIGH_BYTE_LATCH(lat),
		.DMEM_WR(dw), .DMEM_ADDR(oa), .DMEM_SECTOR(dsec), .DMEM_DATA(dd),
		.BUSY(busy), .SECTOR_ERR(serr));
	ptr_dmem_model ptr_dmem_model_i (.clk(clk), .wr(dw), .addr(oa), .data(dd));
	task chk(input logic [24:0] s, input logic [24:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask : chk
	task report_and_stop;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task wr3(input logic [2:0] k, input logic [7:0] x);
		@(negedge clk);
		{plw, phw, lw} = k;
		wd = x;
		@(negedge clk);
		{plw, phw, lw} = 3'h0;
	endtask : wr3
	task rd(input logic [11:0] a, input logic e, input logic [1:0] s);
		wr3(3'h4, a[7:0]);
		wr3(3'h2, {4'h0, a[11:8]});
		chk(25'({tph, tpl}), 25'(a));
		@(negedge clk);
		st = 1;
		ext = e;
		ds = s;
		da = 9'($random(seed));
		if (e || s == 2'h0) q.push_back({mem[a], da});
		@(negedge clk);
		st = 0;
		chk(25'(serr), 25'(!e && s != 2'h0));
		chk(25'(busy), 25'(e || s == 2'h0));
		@(negedge clk);
		if (e || s == 2'h0) chk(25'(dsec), 25'(s));
	endtask : rd
	always @(negedge clk) begin
		if (dw === 1'b1) begin
			if (q.size() == 0) chk(25'h1, 25'h0);
			else chk({lat, dd, oa}, q.pop_front());
		end
	end
	initial begin
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		for (int i = 0; i < 12; i++) begin
			@(negedge clk);
			pa = i == 0 ? 12'hfff : i == 1 ? 12'h000 : 12'($random(seed));
			pd = 16'($random(seed));
			mem[pa] = pd;
			adr[i] = pa;
			pw = 1;
		end
		@(negedge clk);
		pw = 0;
		for (int i = 0; i < 12; i++) rd(adr[i], i[0], i[2:1]);
		@(negedge clk); // read done before the latch is touched
		chk(25'(ptr_dmem_model_i.mem_q[da]), 25'(mem[adr[11]][7:0]));
		v = 8'($random(seed));
		wr3(3'h1, v);
		chk(25'(lat), 25'(v));
		repeat (3) @(negedge clk);
		chk(25'(lat), 25'(v));
		for (int k = 0; k < 10 && q.size() > 0; k++) @(negedge clk);
		if (q.size() > 0) chk(25'h1, 25'h0);
		report_and_stop();
	end
endmodule : ptr_table_read_tb
bind ptr_table_read ptr_table_read_chk ptr_table_read_chk_i (.*);
